// file: logic/acg_top.sv
// adaptive clock generator: control registers, clock steering, dividers and frame cycle capture
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - control register is eight bits at address ffe1
// - bit 6 high drives the output-divided master clock on its pin, which stays low while bit 2 is clear
// - bit 5 picks cycle counter clock: 0 primary output, 1 secondary output
// - bit 4 picks external clock input: 0 primary pin, 1 secondary pin
// - bit 2 high enables both input and output dividers
// - bits 7, 3, 1:0 read zero and ignore writes
// - output divider divides by field plus one (1..16), input by 1..8
// - free 16-bit counter on selected clock is captured at every frame start
// - 24-bit frequency word in three bytes programs the synthesizer
module acg_top #(
    parameter int FRQ_W = acg_pkg::ACG_FRQ_W,
    parameter int CAP_W = acg_pkg::ACG_CAP_W
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_clk_en,
    input  wire acg_pkg::acg_bus_req_s i_bus,
    output logic [7:0]                o_rdata,
    input  wire logic                 i_sof,
    input  wire logic                 i_ext_clock_mode,
    input  wire logic                 i_codec_clock_in,
    input  wire logic                 i_codec_clock_in_alt,
    output logic                      o_codec_clock_out,
    output logic                      o_codec_clock_out_oe,
    output logic                      o_codec_clock_out_alt
);
    import acg_pkg::*;

    generate
        if (FRQ_W != 24 || CAP_W != 16) begin : g_bad_params
            $error("acg_top: register map serves only 24-bit frequency and 16-bit capture");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // register state
    acg_ctrl_s         ctrl_reg;
    logic [7:0]        div_reg;
    logic [FRQ_W-1:0]  frq_reg;
    logic [CAP_W-1:0]  cap_reg;
    logic [CAP_W-1:0]  cycle_cnt_reg;
    logic [FRQ_W-1:0]  phase_reg;
    logic [7:0]        rdata_reg;
    logic [1:0]        sync_reg [ACG_SYNC_STAGES];
    logic [1:0]        ext_level_reg;
    logic [1:0]        ext_prev_reg;
    logic              synth_prev_reg;
    logic              mclk_prev_reg;
    logic              out_reg;
    logic              out_oe_reg;
    logic              alt_reg;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic         wr_ctrl;
    wire logic         wr_div;
    wire logic         wr_frq2;
    wire logic         wr_frq1;
    wire logic         wr_frq0;
    wire logic [7:0]   ctrl_next;
    wire logic [7:0]   div_next;
    wire logic [7:0]   rdata_next;

    // one write strobe per register, no side effects on read
    assign wr_ctrl = i_bus.wr && (i_bus.addr == ACG_ADDR_CTRL);
    assign wr_div  = i_bus.wr && (i_bus.addr == ACG_ADDR_DIV);
    assign wr_frq2 = i_bus.wr && (i_bus.addr == ACG_ADDR_FRQ2);
    assign wr_frq1 = i_bus.wr && (i_bus.addr == ACG_ADDR_FRQ1);
    assign wr_frq0 = i_bus.wr && (i_bus.addr == ACG_ADDR_FRQ0);

    // reserved bits are masked off at write so they can only ever read zero
    assign ctrl_next = i_bus.wdata & ACG_CTRL_WMASK;
    assign div_next  = i_bus.wdata & ACG_DIV_WMASK;

    // read mux; unmapped addresses answer zero
    assign rdata_next = (i_bus.addr == ACG_ADDR_CTRL)   ? ctrl_reg :
                        (i_bus.addr == ACG_ADDR_DIV)    ? div_reg :
                        (i_bus.addr == ACG_ADDR_CAP_HI) ? cap_reg[15:8] :
                        (i_bus.addr == ACG_ADDR_CAP_LO) ? cap_reg[7:0] :
                        (i_bus.addr == ACG_ADDR_FRQ2)   ? frq_reg[23:16] :
                        (i_bus.addr == ACG_ADDR_FRQ1)   ? frq_reg[15:8] :
                        (i_bus.addr == ACG_ADDR_FRQ0)   ? frq_reg[7:0] : 8'h00;

    // register writes; all bits clear on reset
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= acg_ctrl_s'(ACG_CTRL_RESET);
            div_reg  <= ACG_DIV_RESET;
            frq_reg  <= ACG_FRQ_RESET;
        end else if (i_clk_en) begin
            if (wr_ctrl) ctrl_reg <= acg_ctrl_s'(ctrl_next);
            if (wr_div)  div_reg <= div_next;
            if (wr_frq2) frq_reg[23:16] <= i_bus.wdata;
            if (wr_frq1) frq_reg[15:8] <= i_bus.wdata;
            if (wr_frq0) frq_reg[7:0] <= i_bus.wdata;
        end
    end

    // read data is registered, valid the cycle after the read strobe
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= 8'h00;
        end else if (i_clk_en && i_bus.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // external clock pins: three-stage sampling, change accepted when stages two and three agree
    wire logic [1:0]   ext_rise;
    wire logic         ext_sel_level;
    wire logic         ext_sel_rise;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            always_ff @(posedge i_core_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sync_reg[0][gi]    <= 1'b0;
                    sync_reg[1][gi]    <= 1'b0;
                    sync_reg[2][gi]    <= 1'b0;
                    ext_level_reg[gi]  <= 1'b0;
                    ext_prev_reg[gi]   <= 1'b0;
                end else if (i_clk_en) begin
                    sync_reg[0][gi]    <= (gi == 0) ? i_codec_clock_in : i_codec_clock_in_alt;
                    sync_reg[1][gi]    <= sync_reg[0][gi];
                    sync_reg[2][gi]    <= sync_reg[1][gi];
                    if (sync_reg[1][gi] == sync_reg[2][gi]) ext_level_reg[gi] <= sync_reg[2][gi];
                    ext_prev_reg[gi]   <= ext_level_reg[gi];
                end
            end
            assign ext_rise[gi] = ext_level_reg[gi] & ~ext_prev_reg[gi];
        end
    endgenerate

    // pins are sampled at the core rate, so inputs much above a quarter of it alias
    assign ext_sel_level = ctrl_reg.in_sel ? ext_level_reg[1] : ext_level_reg[0];
    assign ext_sel_rise  = ctrl_reg.in_sel ? ext_rise[1] : ext_rise[0];

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // frequency synthesizer: phase accumulator, top bit is the generated clock
    wire logic         synth_level;
    wire logic         synth_rise;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg      <= '0;
            synth_prev_reg <= 1'b0;
        end else if (i_clk_en) begin
            phase_reg      <= phase_reg + frq_reg;
            synth_prev_reg <= phase_reg[FRQ_W-1];
        end
    end

    assign synth_level = phase_reg[FRQ_W-1];
    assign synth_rise  = synth_level & ~synth_prev_reg;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // dividers; firmware is expected to settle the selects before enabling them
    wire logic         in_div_level;
    wire logic         in_div_rise;
    wire logic         mclk_level;
    wire logic         mclk_rise;
    wire logic         out_div_level;
    wire logic         out_div_rise;
    wire logic         cnt_tick;

    acg_divider #(
        .CNT_W       (ACG_DIVI_W)
    ) u_in_div (
        .i_core_clk  (i_core_clk),
        .i_rstn      (i_rstn),
        .i_clk_en    (i_clk_en),
        .i_enable    (ctrl_reg.div_en),
        .i_src_level (ext_sel_level),
        .i_src_rise  (ext_sel_rise),
        .i_factor    (div_reg[ACG_DIVI_LSB +: ACG_DIVI_W]),
        .o_level     (in_div_level),
        .o_rise      (in_div_rise)
    );

    // master clock comes from the divided external pin or from the synthesizer
    assign mclk_level = i_ext_clock_mode ? in_div_level : synth_level;
    assign mclk_rise  = i_ext_clock_mode ? in_div_rise : synth_rise;

    acg_divider #(
        .CNT_W       (ACG_DIVM_W)
    ) u_out_div (
        .i_core_clk  (i_core_clk),
        .i_rstn      (i_rstn),
        .i_clk_en    (i_clk_en),
        .i_enable    (ctrl_reg.div_en),
        .i_src_level (mclk_level),
        .i_src_rise  (mclk_rise),
        .i_factor    (div_reg[ACG_DIVM_LSB +: ACG_DIVM_W]),
        .o_level     (out_div_level),
        .o_rise      (out_div_rise)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // cycle counter and frame capture
    assign cnt_tick = ctrl_reg.cap_sel ? (mclk_level & ~mclk_prev_reg) : out_div_rise;

    // a tick in the capture cycle is counted after the snapshot, never lost
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cycle_cnt_reg <= ACG_CAP_RESET;
            cap_reg       <= ACG_CAP_RESET;
            mclk_prev_reg <= 1'b0;
        end else if (i_clk_en) begin
            mclk_prev_reg <= mclk_level;
            if (cnt_tick) cycle_cnt_reg <= cycle_cnt_reg + CAP_W'(1);
            if (i_sof)    cap_reg <= cycle_cnt_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // pin drivers; a disabled output is held low as well as released
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_reg    <= 1'b0;
            out_oe_reg <= 1'b0;
            alt_reg    <= 1'b0;
        end else if (i_clk_en) begin
            out_reg    <= ctrl_reg.out_en & out_div_level;
            out_oe_reg <= ctrl_reg.out_en;
            alt_reg    <= mclk_level;
        end
    end

    assign o_rdata               = rdata_reg;
    assign o_codec_clock_out     = out_reg;
    assign o_codec_clock_out_oe  = out_oe_reg;
    assign o_codec_clock_out_alt = alt_reg;
endmodule : acg_top
`default_nettype wire

// file: logic/acg_pkg.sv
// constants, field layouts and carriers for the adaptive clock generator control block
package acg_pkg;
    // byte addresses in the microcontroller memory map
    localparam logic [15:0] ACG_ADDR_CTRL   = 16'hffe1;
    localparam logic [15:0] ACG_ADDR_DIV    = 16'hffe2;
    localparam logic [15:0] ACG_ADDR_CAP_HI = 16'hffe3;
    localparam logic [15:0] ACG_ADDR_CAP_LO = 16'hffe4;
    localparam logic [15:0] ACG_ADDR_FRQ2   = 16'hffe5;
    localparam logic [15:0] ACG_ADDR_FRQ1   = 16'hffe6;
    localparam logic [15:0] ACG_ADDR_FRQ0   = 16'hffe7;

    // control register: writable bits and reset value
    localparam logic [7:0]  ACG_CTRL_WMASK  = 8'h74;
    localparam logic [7:0]  ACG_CTRL_RESET  = 8'h00;

    // divider control register: output factor 7:4, input factor 2:0
    localparam int          ACG_DIVM_LSB    = 4;
    localparam int          ACG_DIVM_W      = 4;
    localparam int          ACG_DIVI_LSB    = 0;
    localparam int          ACG_DIVI_W      = 3;
    localparam logic [7:0]  ACG_DIV_WMASK   = 8'hf7;
    localparam logic [7:0]  ACG_DIV_RESET   = 8'h00;

    // widths of the frequency word and the cycle counter
    localparam int          ACG_FRQ_W       = 24;
    localparam int          ACG_CAP_W       = 16;
    localparam logic [23:0] ACG_FRQ_RESET   = 24'h000000;
    localparam logic [15:0] ACG_CAP_RESET   = 16'h0000;

    // pin synchroniser depth
    localparam int          ACG_SYNC_STAGES = 3;

    // one microcontroller register access
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } acg_bus_req_s;

    // control register layout
    typedef struct packed {
        logic       rsvd7;
        logic       out_en;
        logic       cap_sel;
        logic       in_sel;
        logic       rsvd3;
        logic       div_en;
        logic [1:0] rsvd10;
    } acg_ctrl_s;
endpackage : acg_pkg

// file: logic/acg_divider.sv
// clock divider working on sampled clock levels, divide by factor plus one
`timescale 1ns/1ps
`default_nettype none
module acg_divider #(
    parameter int CNT_W = 4
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_clk_en,
    input  wire logic             i_enable,
    input  wire logic             i_src_level,
    input  wire logic             i_src_rise,
    input  wire logic [CNT_W-1:0] i_factor,
    output logic                  o_level,
    output logic                  o_rise
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             level_reg;
    logic             level_next;
    logic             rise_reg;
    wire  logic       bypass;
    wire  logic [CNT_W:0] half;

    generate
        if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
            $error("acg_divider: CNT_W out of range");
        end
    endgenerate

    // high for the first half of the count; even factors (odd divide ratios) get the longer high phase
    assign bypass     = (i_factor == '0);
    assign half       = ({1'b0, i_factor} + (CNT_W+1)'(2)) >> 1;   // ceil of (factor + 1) / 2
    assign cnt_next   = !i_enable ? '0 :
                        (i_src_rise ? ((cnt_reg == i_factor) ? '0 : cnt_reg + CNT_W'(1)) : cnt_reg);
    assign level_next = !i_enable ? 1'b0 :
                        (bypass ? i_src_level : ({1'b0, cnt_next} < half));

    // state only moves while the clock enable is high
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg   <= '0;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
        end else if (i_clk_en) begin
            cnt_reg   <= cnt_next;
            level_reg <= level_next;
            rise_reg  <= level_next & ~level_reg;
        end
    end

    assign o_level = level_reg;
    assign o_rise  = rise_reg;
endmodule : acg_divider
`default_nettype wire

// file: bench/acg_top_props.sv
// concurrent property checker for the adaptive clock generator control block
`timescale 1ns/1ps
`default_nettype none
module acg_top_props (
    input wire logic                  i_core_clk,
    input wire logic                  i_rstn,
    input wire logic                  i_clk_en,
    input wire acg_pkg::acg_bus_req_s i_bus,
    input wire logic [7:0]            o_rdata,
    input wire logic                  o_codec_clock_out,
    input wire logic                  o_codec_clock_out_oe
);
    import acg_pkg::*;
    logic [7:0]  ctl_reg;
    logic [7:0]  div_reg;
    logic [23:0] frq_reg;
    wire         wr_ok = i_clk_en && i_bus.wr;
    wire         rd_ok = i_clk_en && i_bus.rd;
    wire         off_map = i_bus.addr < ACG_ADDR_CTRL || i_bus.addr > ACG_ADDR_FRQ0;
    ////////////////////////////////////////////////////////////
    // shadow of the writable bits, kept from the bus alone
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl_reg <= 8'h00;
            div_reg <= 8'h00;
            frq_reg <= 24'h000000;
        end else if (wr_ok) begin
            case (i_bus.addr)
                ACG_ADDR_CTRL: ctl_reg <= i_bus.wdata & 8'h74;
                ACG_ADDR_DIV:  div_reg <= i_bus.wdata & 8'hf7;
                ACG_ADDR_FRQ2: frq_reg[23:16] <= i_bus.wdata;
                ACG_ADDR_FRQ1: frq_reg[15:8] <= i_bus.wdata;
                ACG_ADDR_FRQ0: frq_reg[7:0] <= i_bus.wdata;
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////
    // one clock domain, so clocking and disable are shared
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    ctrl_read_back_a: assert property (rd_ok && i_bus.addr == ACG_ADDR_CTRL
        |=> o_rdata == $past(ctl_reg))
        else $error("control read differs from last write");
    rsvd_bits_zero_a: assert property (rd_ok && i_bus.addr == ACG_ADDR_CTRL
        |=> (o_rdata & 8'h8b) == 8'h00)
        else $error("reserved control bits read nonzero");
    div_read_back_a: assert property (rd_ok && i_bus.addr == ACG_ADDR_DIV
        |=> o_rdata == $past(div_reg))
        else $error("divider read differs from last write");
    frq_read_back_a: assert property (rd_ok && i_bus.addr == ACG_ADDR_FRQ2
        |=> o_rdata == $past(frq_reg[23:16]))
        else $error("frequency top byte read wrong");
    off_map_zero_a: assert property (rd_ok && off_map
        |=> o_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    rdata_hold_a: assert property (!rd_ok
        |=> $stable(o_rdata))
        else $error("read data moved without a read");
    oe_tracks_bit_a: assert property ($past(i_clk_en)
        |-> o_codec_clock_out_oe == $past(ctl_reg[6]))
        else $error("pin enable does not follow control bit");
    out_needs_oe_a: assert property (o_codec_clock_out
        |-> o_codec_clock_out_oe)
        else $error("clock driven while pin disabled");
    div_off_quiet_a: assert property ((i_clk_en && !ctl_reg[2]) [*3]
        |-> !o_codec_clock_out)
        else $error("divided clock moves while dividers off");
endmodule : acg_top_props
bind acg_top acg_top_props u_props (.i_core_clk, .i_rstn, .i_clk_en, .i_bus, .o_rdata,
    .o_codec_clock_out, .o_codec_clock_out_oe);
`default_nettype wire

// file: bench/acg_top_tb.sv
// self-checking bench for the adaptive clock generator control block
`timescale 1ns/1ps
`default_nettype none
module acg_top_tb;
    import acg_pkg::*;
    logic         i_core_clk;
    logic         i_rstn;
    logic         i_clk_en;
    acg_bus_req_s i_bus;
    logic [7:0]   o_rdata;
    logic         i_sof;
    logic         i_ext_clock_mode;
    logic         i_codec_clock_in = 1'b0;
    logic         i_codec_clock_in_alt = 1'b0;
    logic         o_codec_clock_out;
    logic         o_codec_clock_out_oe;
    logic         o_codec_clock_out_alt;
    int           bad_count;
    int           check_count;
    int           pin_cnt = 0;
    int           alt_rise = 0;
    logic         alt_prev = 1'b0;
    logic [7:0]   rd_val;
    logic [15:0]  cap_a;
    logic [15:0]  cap_b;
    logic [15:0]  t_a [7] = '{ACG_ADDR_CTRL, ACG_ADDR_DIV, ACG_ADDR_FRQ2, ACG_ADDR_FRQ1, ACG_ADDR_FRQ0,
                              ACG_ADDR_CAP_HI, 16'hffe8};
    logic [7:0]   t_w [7] = '{8'hff, 8'hff, 8'ha5, 8'h5a, 8'h3c, 8'hff, 8'hff};
    logic [7:0]   t_e [7] = '{8'h74, 8'hf7, 8'ha5, 8'h5a, 8'h3c, 8'h00, 8'h00};
    acg_top uut (.i_core_clk, .i_rstn, .i_clk_en, .i_bus, .o_rdata, .i_sof, .i_ext_clock_mode,
        .i_codec_clock_in, .i_codec_clock_in_alt, .o_codec_clock_out, .o_codec_clock_out_oe,
        .o_codec_clock_out_alt);
    ////////////////////////////////////////////////////////////
    // 25 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    // external clock pins, period 10 and 20 core cycles
    always @(posedge i_core_clk) begin
        pin_cnt <= pin_cnt + 1;
        i_codec_clock_in <= (pin_cnt % 10) < 5;
        i_codec_clock_in_alt <= (pin_cnt % 20) < 10;
    end
    // rising edges of the undivided clock pin, sampled mid-cycle where it is settled
    always @(negedge i_core_clk) begin
        alt_prev <= o_codec_clock_out_alt;
        if (o_codec_clock_out_alt && !alt_prev) alt_rise <= alt_rise + 1;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one access held for a single taken edge, read data sampled mid-cycle
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge i_core_clk);
        i_bus <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge i_core_clk);
        i_bus <= '0;
        @(negedge i_core_clk);
        rd_val = o_rdata;
    endtask : bus
    task automatic pulse_sof();
        @(posedge i_core_clk);
        i_sof <= 1'b1;
        @(posedge i_core_clk);
        i_sof <= 1'b0;
    endtask : pulse_sof
    // counts between two frame starts 796 cycles apart; edge phase allows two off
    task automatic measure(input string name, input int exp, input int exp_alt);
        int d;
        int a0;
        pulse_sof();
        a0 = alt_rise;
        bus(ACG_ADDR_CAP_HI, 1'b0, 8'h00);
        cap_a[15:8] = rd_val;
        bus(ACG_ADDR_CAP_LO, 1'b0, 8'h00);
        cap_a[7:0] = rd_val;
        repeat (790) @(posedge i_core_clk);
        pulse_sof();
        d = alt_rise - a0;
        chk({name, " alt"}, 8'(d >= exp_alt - 2 && d <= exp_alt + 2), 8'h01);
        bus(ACG_ADDR_CAP_HI, 1'b0, 8'h00);
        cap_b[15:8] = rd_val;
        bus(ACG_ADDR_CAP_LO, 1'b0, 8'h00);
        cap_b[7:0] = rd_val;
        d = int'(cap_b - cap_a);
        chk(name, 8'(d >= exp - 2 && d <= exp + 2), 8'h01);
    endtask : measure
    task automatic results();
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////
    // watchdog, about twice the expected run
    initial begin
        #400000;
        bad_count++;
        results();
    end
    initial begin
        i_rstn = 1'b0;
        i_clk_en = 1'b1;
        i_bus = '0;
        i_sof = 1'b0;
        i_ext_clock_mode = 1'b0;
        bad_count = 0;
        check_count = 0;
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        for (int a = 16'hffe0; a <= 16'hffe8; a++) begin
            bus(16'(a), 1'b0, 8'h00);
            chk("reset value", rd_val, 8'h00);
        end
        // write masks, read-only capture and unmapped space
        for (int i = 0; i < 7; i++) begin
            bus(t_a[i], 1'b1, t_w[i]);
            bus(t_a[i], 1'b0, 8'h00);
            chk("write readback", rd_val, t_e[i]);
        end
        // a write while frozen must not land
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        bus(ACG_ADDR_DIV, 1'b1, 8'h33);
        @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        bus(ACG_ADDR_DIV, 1'b0, 8'h00);
        chk("frozen write", rd_val, 8'hf7);
        // master at one eighth of core rate, output divide by two
        bus(ACG_ADDR_CTRL, 1'b1, 8'h00);
        bus(ACG_ADDR_DIV, 1'b1, 8'h10);
        bus(ACG_ADDR_FRQ2, 1'b1, 8'h20);
        bus(ACG_ADDR_FRQ1, 1'b1, 8'h00);
        bus(ACG_ADDR_FRQ0, 1'b1, 8'h00);
        bus(ACG_ADDR_CTRL, 1'b1, 8'h40);
        bus(ACG_ADDR_CTRL, 1'b1, 8'h44);
        chk("pin enable", {7'h00, o_codec_clock_out_oe}, 8'h01);
        measure("divided count", 50, 100);
        // selects change only while the dividers are off
        bus(ACG_ADDR_CTRL, 1'b1, 8'h60);
        bus(ACG_ADDR_CTRL, 1'b1, 8'h64);
        measure("master count", 100, 100);
        @(posedge i_core_clk);
        i_ext_clock_mode <= 1'b1;
        measure("primary pin count", 80, 80);
        bus(ACG_ADDR_CTRL, 1'b1, 8'h70);
        bus(ACG_ADDR_CTRL, 1'b1, 8'h74);
        measure("secondary pin count", 40, 40);
        // input divide by three on the secondary pin, period 60 core cycles
        bus(ACG_ADDR_DIV, 1'b1, 8'h12);
        measure("input divide count", 13, 13);
        bus(ACG_ADDR_CTRL, 1'b1, 8'h40);
        measure("divider off count", 0, 0);
        chk("static output", {7'h00, o_codec_clock_out}, 8'h00);
        bus(ACG_ADDR_CAP_LO, 1'b1, 8'hff);
        bus(ACG_ADDR_CAP_LO, 1'b0, 8'h00);
        chk("capture read only", rd_val, cap_b[7:0]);
        // clearing the enable releases the pin and parks it low
        bus(ACG_ADDR_CTRL, 1'b1, 8'h00);
        bus(ACG_ADDR_CTRL, 1'b0, 8'h00);
        chk("pin disable", {6'h00, o_codec_clock_out_oe, o_codec_clock_out}, 8'h00);
        results();
    end
endmodule : acg_top_tb
`default_nettype wire
